// >>> rtl/scd_pkg.sv
// What this block does
// - full-synchronous config bit 1 aligns control cycle start to host timing count.
// - config bit 0 selects 16-byte (0) or 32-byte (1) frame size.
// - config bit 4 enables external scale monitoring under semi-closed control.
// - semi-synchronous mode aligns reception timing only, timing count ignored.
// - timing count not advancing in full-sync mode blocks link established.
// - command/response flag in header bit 7 must be zero, else alarm 86.0.
// - node address mismatch raises alarm 86.0.
// - update counter change marks new command; counter echoed in response.
// - energize request is byte 2 bit 7 ANDed with external input if assigned.
// - gain select bit 4 acts only with auto tuning off, second gain, link switch.
// - torque limit switch bit 3 acts only when selection setting is 3 or 4.
// - home trigger armed by byte 2 bit 2 only during homing command.
// - hard stop bit halts profile generation at once in profile mode.
// - smooth stop bit decelerates until profile fully stops.
// - pause bit decelerates and holds profile paused.
// - speed limit switch acts in torque mode only when selection setting is 1.
// - aux output bits drive transistors only when assigned; no servo effect.
// - unsupported cyclic command code raises alarm 86.1.
package scd_pkg;
   // config register bit positions
   localparam int CFG_FRAME32_BIT = 0;
   localparam int CFG_FULLSYNC_BIT = 1;
   localparam int CFG_SCALE_MON_BIT = 4;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // header byte fields
   localparam int HDR_CR_BIT = 7;
   localparam int NODE_W = 5;
   localparam int UPD_W = 2;
   localparam int UPD_LSB = 5;
   // control byte 2
   localparam int B2_ENERGIZE = 7;
   localparam int B2_GAIN = 4;
   localparam int B2_TORQUE = 3;
   localparam int B2_HOMING = 2;
   // control byte 3
   localparam int B3_HARD = 7;
   localparam int B3_SMOOTH = 6;
   localparam int B3_PAUSE = 5;
   localparam int B3_SPEED = 3;
   localparam int B3_AUX2 = 1;
   localparam int B3_AUX1 = 0;
   // byte 1 cyclic code field
   localparam int CYC_LSB = 4;
   localparam int CYC_W = 3;
   localparam logic [2:0] CODE_NOP = 3'h0;
   // setting values
   localparam logic [2:0] TL_SEL_A = 3'h3;
   localparam logic [2:0] TL_SEL_B = 3'h4;
   localparam logic [1:0] SL_SEL_ON = 2'h1;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int SYNC_PERIOD_US = 2000;
   localparam int SYNC_CYCLES = CLK_HZ / 1_000_000 * SYNC_PERIOD_US;
   localparam int SYNC_SLACK = SYNC_CYCLES / 4;

   typedef struct packed {
      logic [7:0] hdr;
      logic [7:0] code;
      logic [7:0] ctl2;
      logic [7:0] ctl3;
      logic [15:0] tmg;
   } scd_frame_t;

   typedef struct packed {
      logic energize;
      logic gain2;
      logic torque_sw;
      logic home_arm;
      logic hard_stop;
      logic smooth_stop;
      logic pause;
      logic speed_sw;
      logic aux_output_one;
      logic aux_output_two;
   } scd_ctl_t;

   typedef struct packed {
      logic auto_tune_on;
      logic gain2_enabled;
      logic link_gain_set_select;
      logic [2:0] torque_limit_selection_setting;
      logic [1:0] speed_limit_selection_setting;
      logic ext_energize_assigned;
      logic aux_one_assigned;
      logic aux_two_assigned;
      logic profile_position_mode;
      logic cyclic_torque_mode;
      logic homing_cmd;
   } scd_setup_t;
endpackage

// >>> rtl/scd_code_check.sv
`timescale 1ns/100ps
module scd_code_check #(
   parameter logic [7:0] SUPPORTED = 8'h1f
) (
   input wire logic [2:0] code,
   output logic bad
);
   // unsupported cyclic code check
   always_comb begin
      bad = ~SUPPORTED[code];
   end
endmodule // scd_code_check

// >>> rtl/scd_sync_mon.sv
`timescale 1ns/100ps
module scd_sync_mon #(
   parameter int PERIOD = 40000,
   parameter int SLACK = 10000
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic frame_valid,
   input wire logic [15:0] tmg,
   output logic cycle_start,
   output logic sync_ok
);
   if (PERIOD < 2 || SLACK >= PERIOD) begin : g_bad_period
      $error("scd_sync_mon: bad period");
   end
   logic [15:0] last_r, last_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic ok_r, ok_nxt;
   logic start_r, start_nxt;
   logic adv;
   always_comb begin
      adv = frame_valid && (tmg != last_r);
      last_nxt = adv ? tmg : last_r;
      cnt_nxt = cnt_r + 32'd1;
      ok_nxt = ok_r;
      start_nxt = 1'b0;
      if (!enable) begin
         cnt_nxt = '0;
         ok_nxt = 1'b0;
      end else if (adv) begin
         start_nxt = 1'b1;
         ok_nxt = (tmg == last_r + 16'd1) && (cnt_r >= 32'(PERIOD - SLACK));
         cnt_nxt = '0;
      end else if (cnt_r > 32'(PERIOD + SLACK)) begin
         ok_nxt = 1'b0;
         cnt_nxt = cnt_r;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last_r <= '0;
         cnt_r <= '0;
         ok_r <= 1'b0;
         start_r <= 1'b0;
      end else begin
         last_r <= last_nxt;
         cnt_r <= cnt_nxt;
         ok_r <= ok_nxt;
         start_r <= start_nxt;
      end
   end
   assign cycle_start = start_r;
   assign sync_ok = ok_r;
endmodule // scd_sync_mon

// >>> rtl/scd_decode.sv
`timescale 1ns/100ps
module scd_decode #(
   parameter logic [7:0] SUPPORTED_CODES = 8'h1f,
   parameter int SYNC_PERIOD = scd_pkg::SYNC_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cfg_we,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata,
   input wire logic frame_valid,
   input wire scd_pkg::scd_frame_t frame,
   input wire scd_pkg::scd_setup_t setup,
   input wire logic [scd_pkg::NODE_W-1:0] node_address,
   input wire logic ext_energize_input,
   output logic frame_32byte,
   output logic scale_monitor_en,
   output logic full_sync,
   output logic cycle_start,
   output logic link_established,
   output logic new_command,
   output logic [scd_pkg::UPD_W-1:0] echo_counter,
   output logic alarm_86_0,
   output logic alarm_86_1,
   output scd_pkg::scd_ctl_t ctl,
   output logic link_status_lamp
);
   import scd_pkg::*;
   if (SYNC_PERIOD < 4) begin : g_bad_sync_period
      $error("scd_decode: sync period too short");
   end

   // ------------------------------------------
   // configuration register
   // ------------------------------------------
   logic [15:0] cfg_r, cfg_nxt;
   always_comb begin
      cfg_nxt = cfg_we ? cfg_wdata : cfg_r;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_r <= CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end
   assign cfg_rdata = cfg_r;
   assign frame_32byte = cfg_r[CFG_FRAME32_BIT];
   assign scale_monitor_en = cfg_r[CFG_SCALE_MON_BIT];
   assign full_sync = cfg_r[CFG_FULLSYNC_BIT];

   // ------------------------------------------
   // header checks
   // ------------------------------------------
   logic code_bad;
   scd_code_check #(.SUPPORTED(SUPPORTED_CODES)) u_code (
      .code(frame.code[CYC_LSB +: CYC_W]),
      .bad(code_bad)
   );
   logic sync_ok, sync_start;
   // timing count only in full sync
   scd_sync_mon #(.PERIOD(SYNC_PERIOD), .SLACK(SYNC_PERIOD / 4)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .enable(full_sync),
      .frame_valid(frame_valid),
      .tmg(frame.tmg),
      .cycle_start(sync_start),
      .sync_ok(sync_ok)
   );

   typedef enum logic [1:0] {ST_IDLE, ST_RUN} scd_state_t;
   scd_state_t st_r, st_nxt;
   logic [UPD_W-1:0] upd_r, upd_nxt;
   logic a0_r, a0_nxt, a1_r, a1_nxt, new_r, new_nxt, rx_r, rx_nxt;
   scd_ctl_t ctl_r, ctl_nxt;
   logic hdr_ok;
   logic [UPD_W-1:0] upd_in;
   always_comb begin
      upd_in = frame.hdr[UPD_LSB +: UPD_W];
      hdr_ok = !frame.hdr[HDR_CR_BIT] && (frame.hdr[NODE_W-1:0] == node_address);
      st_nxt = st_r;
      upd_nxt = upd_r;
      a0_nxt = a0_r;
      a1_nxt = a1_r;
      new_nxt = 1'b0;
      rx_nxt = 1'b0;
      ctl_nxt = ctl_r;
      if (frame_valid) begin
         if (!hdr_ok) begin
            a0_nxt = 1'b1;
         end
         if (code_bad) begin
            a1_nxt = 1'b1;
         end
         if (hdr_ok) begin
            case (st_r)
               ST_IDLE: begin
                  st_nxt = ST_RUN;
                  upd_nxt = upd_in;
                  new_nxt = 1'b1;
               end
               ST_RUN: begin
                  new_nxt = (upd_in != upd_r);
                  upd_nxt = upd_in;
               end
               default: st_nxt = ST_IDLE;
            endcase
         end
      end
      if (new_nxt) begin
         rx_nxt = 1'b1;
         ctl_nxt.energize = frame.ctl2[B2_ENERGIZE]
            & (ext_energize_input | ~setup.ext_energize_assigned);
         if (!setup.auto_tune_on && setup.gain2_enabled && setup.link_gain_set_select) begin
            ctl_nxt.gain2 = frame.ctl2[B2_GAIN];
         end
         ctl_nxt.torque_sw = frame.ctl2[B2_TORQUE]
            & ((setup.torque_limit_selection_setting == TL_SEL_A)
               | (setup.torque_limit_selection_setting == TL_SEL_B));
         ctl_nxt.home_arm = frame.ctl2[B2_HOMING] & setup.homing_cmd;
         ctl_nxt.hard_stop = frame.ctl3[B3_HARD] & setup.profile_position_mode;
         ctl_nxt.smooth_stop = frame.ctl3[B3_SMOOTH] & setup.profile_position_mode;
         ctl_nxt.pause = frame.ctl3[B3_PAUSE] & setup.profile_position_mode;
         ctl_nxt.speed_sw = frame.ctl3[B3_SPEED] & setup.cyclic_torque_mode
            & (setup.speed_limit_selection_setting == SL_SEL_ON);
         ctl_nxt.aux_output_one = frame.ctl3[B3_AUX1] & setup.aux_one_assigned;
         ctl_nxt.aux_output_two = frame.ctl3[B3_AUX2] & setup.aux_two_assigned;
      end
      if (setup.ext_energize_assigned && !ext_energize_input) begin
         ctl_nxt.energize = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= ST_IDLE;
         upd_r <= '0;
         a0_r <= 1'b0;
         a1_r <= 1'b0;
         new_r <= 1'b0;
         rx_r <= 1'b0;
         ctl_r <= '0;
      end else begin
         st_r <= st_nxt;
         upd_r <= upd_nxt;
         a0_r <= a0_nxt;
         a1_r <= a1_nxt;
         new_r <= new_nxt;
         rx_r <= rx_nxt;
         ctl_r <= ctl_nxt;
      end
   end
   assign new_command = new_r;
   assign echo_counter = upd_r;
   assign alarm_86_0 = a0_r;
   assign alarm_86_1 = a1_r;
   assign ctl = ctl_r;
   assign cycle_start = full_sync ? sync_start : rx_r;
   assign link_established = (st_r == ST_RUN) && !a0_r && !a1_r && (!full_sync || sync_ok);
   assign link_status_lamp = link_established;
endmodule // scd_decode

// >>> sim/scd_host_model.sv
`timescale 1ns/100ps
module scd_host_model
   import scd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic go,
   input wire scd_pkg::scd_frame_t req,
   output logic frame_valid = 1'b0,
   output scd_pkg::scd_frame_t frame = '0
);
   logic [UPD_W-1:0] upd_r = 2'h1;
   logic [15:0] tmg_r = 16'h0;
   // ----------------
   // frame generation
   // ----------------
   always @(negedge clk) begin
      frame_valid <= go;
      if (sys_rst) begin
         upd_r <= 2'h1;
      end
      if (go && !sys_rst) begin
         frame <= {req.hdr[7], upd_r, req.hdr[4:0], req[39:16], tmg_r};
         upd_r <= upd_r + 2'h1;
         tmg_r <= tmg_r + 16'h1;
      end else begin
         // idle bus inverts its previous value every cycle, so it alternates between the inverse of the last frame and the last frame
         frame <= ~frame;
      end
   end
endmodule // scd_host_model

// >>> sim/scd_decode_sva.sv
`timescale 1ns/100ps
module scd_decode_sva
   import scd_pkg::*;
#(
   parameter logic [7:0] SUPPORTED_CODES = 8'h1f,
   parameter int SYNC_PERIOD = 40000
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cfg_we,
   input wire logic [15:0] cfg_wdata,
   input wire logic frame_valid,
   input wire scd_pkg::scd_frame_t frame,
   input wire logic [scd_pkg::NODE_W-1:0] node_address,
   input wire logic frame_32byte,
   input wire logic scale_monitor_en,
   input wire logic full_sync,
   input wire logic cycle_start,
   input wire logic new_command,
   input wire logic [scd_pkg::UPD_W-1:0] echo_counter,
   input wire logic alarm_86_0,
   input wire logic alarm_86_1
);
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   property p_size;
      cfg_we |=> frame_32byte == $past(cfg_wdata[CFG_FRAME32_BIT]);
   endproperty
   a_size: assert property (p_size) else $error("frame size bit");
   property p_sync;
      cfg_we |=> full_sync == $past(cfg_wdata[CFG_FULLSYNC_BIT]);
   endproperty
   a_sync: assert property (p_sync) else $error("sync mode bit");
   property p_scale;
      cfg_we |=> scale_monitor_en == $past(cfg_wdata[CFG_SCALE_MON_BIT]);
   endproperty
   a_scale: assert property (p_scale) else $error("scale bit");
   property p_cr;
      frame_valid && frame.hdr[HDR_CR_BIT] |=> alarm_86_0 && !new_command;
   endproperty
   a_cr: assert property (p_cr) else $error("flag alarm");
   property p_node;
      frame_valid && frame.hdr[NODE_W-1:0] != node_address |=> alarm_86_0 && !new_command;
   endproperty
   a_node: assert property (p_node) else $error("node alarm");
   property p_echo;
      new_command |-> echo_counter == $past(frame.hdr[UPD_LSB+1:UPD_LSB]);
   endproperty
   a_echo: assert property (p_echo) else $error("echo value");
   property p_code;
      frame_valid && !SUPPORTED_CODES[frame.code[CYC_LSB+2:CYC_LSB]] |=> alarm_86_1;
   endproperty
   a_code: assert property (p_code) else $error("code alarm");
   property p_semi;
      new_command && !full_sync |-> cycle_start;
   endproperty
   a_semi: assert property (p_semi) else $error("cycle start");
   c_cr: cover property (frame_valid && frame.hdr[HDR_CR_BIT]);
   c_new: cover property (new_command);
   c_sync: cover property (cycle_start && full_sync);
endmodule // scd_decode_sva

bind scd_decode scd_decode_sva #(
   .SUPPORTED_CODES(SUPPORTED_CODES),
   .SYNC_PERIOD(SYNC_PERIOD)
) u_sva (.*);

// >>> sim/scd_decode_tb.sv
`timescale 1ns/100ps
module scd_decode_tb;
   import scd_pkg::*;
   localparam int PER = 40;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cfg_we = 1'b0;
   logic [15:0] cfg_wdata = 16'h0;
   logic [15:0] cfg_rdata;
   logic frame_valid;
   logic go = 1'b0;
   scd_frame_t frame;
   scd_frame_t req = '0;
   scd_setup_t setup = '0;
   logic [NODE_W-1:0] node_address = 5'h15;
   logic ext_energize_input = 1'b0;
   logic frame_32byte, scale_monitor_en, full_sync, cycle_start, link_established;
   logic new_command, alarm_86_0, alarm_86_1, link_status_lamp;
   logic [UPD_W-1:0] echo_counter, upd;
   scd_ctl_t ctl;
   logic [7:0] c2, c3;
   logic g2;
   int fails = 0;
   int cmp_count = 0;
   always #25 clk = ~clk;
   scd_decode #(.SYNC_PERIOD(PER)) DUT (.*);
   scd_host_model host (.*);
   // -----
   // tasks
   // -----
   task chk(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %b exp %b", $time, got, exp);
      end
   endtask
   task rst();
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
   endtask
   task wcfg(input logic [15:0] d);
      @(negedge clk);
      cfg_we = 1'b1;
      cfg_wdata = d;
      @(negedge clk);
      cfg_we = 1'b0;
   endtask
   task send(input logic [7:0] h, input logic [2:0] cd, input int gap);
      @(posedge clk);
      go <= 1'b1;
      req <= {h, 1'b0, cd, 4'h0, c2, c3, 16'h0};
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      repeat (gap) @(negedge clk);
   endtask
   function automatic scd_ctl_t ex();
      scd_ctl_t e;
      e.energize = c2[B2_ENERGIZE] && (!setup.ext_energize_assigned || ext_energize_input);
      e.gain2 = g2;
      e.torque_sw = c2[B2_TORQUE] && (setup.torque_limit_selection_setting inside {TL_SEL_A, TL_SEL_B});
      e.home_arm = c2[B2_HOMING] && setup.homing_cmd;
      e.hard_stop = c3[B3_HARD] && setup.profile_position_mode;
      e.smooth_stop = c3[B3_SMOOTH] && setup.profile_position_mode;
      e.pause = c3[B3_PAUSE] && setup.profile_position_mode;
      e.speed_sw = c3[B3_SPEED] && setup.cyclic_torque_mode && setup.speed_limit_selection_setting == SL_SEL_ON;
      e.aux_output_one = c3[B3_AUX1] && setup.aux_one_assigned;
      e.aux_output_two = c3[B3_AUX2] && setup.aux_two_assigned;
      return e;
   endfunction
   task conclude();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      conclude();
   end
   // -----
   // tests
   // -----
   initial begin
      void'($urandom(32'hbddd));
      c2 = 8'h0;
      c3 = 8'h0;
      rst();
      chk(cfg_rdata === CFG_RESET, 1'b1);
      for (int i = 0; i < 8; i++) begin
         wcfg({11'h0, i[2], 2'h0, i[1:0]});
         chk(cfg_rdata === cfg_wdata, 1'b1);
         chk(frame_32byte, cfg_wdata[0]);
         chk(full_sync, cfg_wdata[1]);
         chk(scale_monitor_en, cfg_wdata[4]);
      end
      wcfg(16'h0);
      $display("config test done");
      upd = 2'h1;
      g2 = 1'b0;
      for (int i = 0; i < 24; i++) begin
         setup = scd_setup_t'(14'($urandom));
         ext_energize_input = 1'($urandom);
         c2 = 8'($urandom) & 8'h9c;
         c3 = 8'($urandom) & 8'heb;
         if (!setup.auto_tune_on && setup.gain2_enabled && setup.link_gain_set_select) begin
            g2 = c2[B2_GAIN];
         end
         send({3'h0, node_address}, 3'($urandom_range(4)), 0);
         chk(new_command, 1'b1);
         chk(echo_counter === upd, 1'b1);
         chk(ctl === ex(), 1'b1);
         chk(cycle_start, 1'b1);
         upd++;
         @(negedge clk);
      end
      chk(alarm_86_1, 1'b0);
      $display("frame test done");
      send({3'h0, node_address ^ 5'h01}, 3'h1, 0);
      chk(new_command, 1'b0);
      chk(alarm_86_0, 1'b1);
      rst();
      send({3'h4, node_address}, 3'h1, 0);
      chk(new_command, 1'b0);
      chk(alarm_86_0, 1'b1);
      for (int i = 5; i < 8; i++) begin
         rst();
         send({3'h0, node_address}, 3'(i), 0);
         chk(alarm_86_1, 1'b1);
         chk(alarm_86_0, 1'b0);
      end
      $display("refusal test done");
      for (int k = 0; k < 2; k++) begin
         rst();
         wcfg(16'h0002);
         repeat (5) send({3'h0, node_address}, 3'h1, k ? 3 : PER - 2);
         chk(link_established, k == 0);
         chk(link_status_lamp, k == 0);
      end
      $display("sync test done");
      conclude();
   end
endmodule // scd_decode_tb
